// ---- inc/esmc_defines.svh ----
// constants for the external static memory controller
`ifndef ESMC_DEFINES_SVH
`define ESMC_DEFINES_SVH

// -----------------------------------------------------------------
// system address decode
// -----------------------------------------------------------------
`define ESMC_REGION_HI      31
`define ESMC_REGION_LO      29
`define ESMC_REGION_CODE    3'h2
`define ESMC_BANK_HI        28
`define ESMC_BANK_LO        26
`define ESMC_NUM_BANKS      8
`define ESMC_ADDR_W         24
`define ESMC_PAGE_LO        4

// -----------------------------------------------------------------
// per-bank configuration field widths
// -----------------------------------------------------------------
`define ESMC_WAIT_W         5
`define ESMC_IDLE_W         4
`define ESMC_WIDTH_W        2

// -----------------------------------------------------------------
// timing
// -----------------------------------------------------------------
`define ESMC_SYNC_LAT       6'h03
`define ESMC_CNT_W          6

`endif

// ---- inc/esmc_pkg.sv ----
// types for the external static memory controller
package esmc_pkg;

   typedef enum logic [1:0] {
      ESMC_W8  = 2'h0,
      ESMC_W16 = 2'h1,
      ESMC_W32 = 2'h2
   } esmc_width_t;

   typedef enum {
      ESMC_IDLE,
      ESMC_TURN,
      ESMC_STROBE,
      ESMC_HOLD
   } esmc_state_t;

endpackage : esmc_pkg

// ---- hw/esmc_sync.sv ----
// two-stage synchroniser for the external data bus
`timescale 1ns/10ps

module esmc_sync (
   input  wire logic        clk,
   input  wire logic        resetn,
   input  wire logic [31:0] async_in,
   output logic      [31:0] sync_out
);

   logic [31:0] meta_q;
   logic [31:0] sync_q;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_q <= 32'h0;
         sync_q <= 32'h0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;

endmodule : esmc_sync

// ---- hw/esmc_ctrl.sv ----
// external static memory controller: system request to external bus cycles
//
// Overview of operation
// - eight banks, each configured on its own, each at most 16 MB.
// - one select output per bank, polarity per bank high or low.
// - address is external only when bits 31 to 29 equal 010.
// - bits 28 to 26 pick the bank, 000 bank 0 up to 111 bank 7.
// - bits 25 and 24 are ignored, so nonzero values mirror the bank.
// - bits 23 to 2 drive the 24-bit external address bus; bits 1 and 0 come from the beat.
// - each bank's data width is 8, 16 or 32 bits.
// - separate read and write wait states, up to 31, per bank.
// - turnaround idle cycles programmable from one to 16.
// - a write after a read to the same bank waits the idle cycles.
// - burst banks use separate first and following access wait counts.
// - burst reads switched on or off per bank.
// - page-mode reads for unclocked memories.
// - four byte lane selects; option decides their use on reads.
// - write strobe low only on writes, output enable low only on reads.
// - data bus driven on writes, sampled on reads, released otherwise.
`timescale 1ns/10ps
`include "esmc_defines.svh"

module esmc_ctrl
   import esmc_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // system side
   input  wire logic        sys_req,
   input  wire logic        sys_write,
   input  wire logic [31:0] sys_addr,
   input  wire logic [3:0]  sys_byte_en,
   input  wire logic [31:0] sys_wdata,
   output logic             sys_ready,
   output logic             sys_error,
   output logic             sys_wait,
   output logic [31:0]      sys_rdata,
   // per-bank configuration, bank n in slice n
   input  wire logic [7:0]  cfg_select_pol,
   input  wire logic [15:0] cfg_data_width,
   input  wire logic [39:0] cfg_read_wait,
   input  wire logic [39:0] cfg_write_wait,
   input  wire logic [39:0] cfg_burst_wait,
   input  wire logic [31:0] cfg_turnaround_idle_cycles,
   input  wire logic [7:0]  cfg_burst_en,
   input  wire logic [7:0]  cfg_write_protect,
   input  wire logic [7:0]  cfg_read_lanes_en,
   // external bus
   output logic [7:0]       bank_select_out,
   output logic [3:0]       byte_lane_select_out_n,
   output logic             ext_write_strobe_n,
   output logic             ext_output_enable_n,
   output logic [23:0]      ext_address_bus,
   output logic [31:0]      ext_data_bus_out,
   output logic             ext_data_bus_oe_n,
   input  wire logic [31:0] ext_data_bus_in
);

   // -----------------------------------------------------------------
   // helpers
   // -----------------------------------------------------------------
   function automatic logic [1:0] last_beat(input esmc_width_t w);
      case (w)
         ESMC_W8:  last_beat = 2'h3;
         ESMC_W16: last_beat = 2'h1;
         default:  last_beat = 2'h0;
      endcase
   endfunction : last_beat

   // byte lanes that a beat covers, in system byte order
   function automatic logic [3:0] beat_lanes(input esmc_width_t w, input logic [1:0] b);
      case (w)
         ESMC_W8:  beat_lanes = 4'h1 << b;
         ESMC_W16: beat_lanes = b[0] ? 4'hc : 4'h3;
         default:  beat_lanes = 4'hf;
      endcase
   endfunction : beat_lanes

   // strobe count minus one; reads also cover the synchroniser latency
   function automatic logic [`ESMC_CNT_W-1:0] strobe_len(input logic wr, input logic [4:0] ws);
      strobe_len = wr ? {1'b0, ws} : {1'b0, ws} + `ESMC_SYNC_LAT;
   endfunction : strobe_len

   // -----------------------------------------------------------------
   // state
   // -----------------------------------------------------------------
   esmc_state_t             st_q, st_d;
   logic [23:0]             addr_q;
   logic [2:0]              bank_q;
   logic                    we_q;
   logic [3:0]              be_q;
   logic [31:0]             wdata_q;
   esmc_width_t             width_q;
   logic [1:0]              beat_q;
   logic                    seq_q;
   logic [`ESMC_CNT_W-1:0]  cnt_q;
   logic [31:0]             rdata_q;
   logic                    ready_q;
   logic                    error_q;
   logic                    wait_q;
   logic                    last_rd_q;
   logic                    last_valid_q;
   logic [2:0]              last_bank_q;
   logic [19:0]             last_page_q;
   logic [31:0]             din_sync;

   logic [7:0]              cs_q;
   logic [3:0]              bls_n_q;
   logic                    we_n_q;
   logic                    oe_n_q;
   logic [23:0]             ext_addr_q;
   logic [31:0]             dout_q;
   logic                    doe_n_q;

   // -----------------------------------------------------------------
   // request decode
   // -----------------------------------------------------------------
   wire         take        = (st_q == ESMC_IDLE) && sys_req && !ready_q;
   wire         in_region   = sys_addr[`ESMC_REGION_HI:`ESMC_REGION_LO]
                              == `ESMC_REGION_CODE;
   wire [2:0]   req_bank    = sys_addr[`ESMC_BANK_HI:`ESMC_BANK_LO];
   // bits 25:24 never reach the bus, so they mirror the bank
   wire [23:0]  req_addr    = sys_addr[`ESMC_ADDR_W-1:0];
   wire         req_prot    = sys_write && cfg_write_protect[req_bank];
   wire         req_reject  = !in_region || req_prot;
   wire [3:0]   req_idle    = cfg_turnaround_idle_cycles[req_bank*4 +: 4];
   // idle cycles before a write that follows a read, or on a bank change after a read
   wire         need_turn   = last_valid_q && last_rd_q
                              && (sys_write || req_bank != last_bank_q);
   // next read inside the page just read counts as a following access
   wire         req_seq     = last_valid_q && last_rd_q && !sys_write
                              && cfg_burst_en[req_bank] && req_bank == last_bank_q
                              && req_addr[23:`ESMC_PAGE_LO] == last_page_q;
   // a direct start times from the request, the latched fields are still stale
   wire [4:0]   req_wait    = sys_write ? cfg_write_wait[req_bank*5 +: 5]
                              : req_seq ? cfg_burst_wait[req_bank*5 +: 5]
                              : cfg_read_wait[req_bank*5 +: 5];

   // -----------------------------------------------------------------
   // per-beat values of the latched access
   // -----------------------------------------------------------------
   wire [4:0]   rd_wait_b   = cfg_read_wait[bank_q*5 +: 5];
   wire [4:0]   wr_wait_b   = cfg_write_wait[bank_q*5 +: 5];
   wire [4:0]   bu_wait_b   = cfg_burst_wait[bank_q*5 +: 5];
   wire         burst_b     = cfg_burst_en[bank_q];
   wire [4:0]   rd_wait_sel = seq_q ? bu_wait_b : rd_wait_b;
   wire [`ESMC_CNT_W-1:0] strobe_cnt = strobe_len(we_q,
                              we_q ? wr_wait_b : rd_wait_sel);
   wire [3:0]   lanes       = beat_lanes(width_q, beat_q);
   wire         last_b      = beat_q == last_beat(width_q);
   wire         cnt_zero    = cnt_q == '0;

   wire [23:0]  beat_addr   = (width_q == ESMC_W8)  ? {addr_q[23:2], beat_q} :
                              (width_q == ESMC_W16) ? {addr_q[23:2], beat_q[0], 1'b0} :
                              {addr_q[23:2], 2'h0};
   wire [31:0]  beat_wdata  = (width_q == ESMC_W8)  ? {24'h0, wdata_q[beat_q*8 +: 8]} :
                              (width_q == ESMC_W16) ? {16'h0, wdata_q[beat_q[0]*16 +: 16]} :
                              wdata_q;
   wire [3:0]   beat_be     = (width_q == ESMC_W8)  ? {3'h0, |(be_q & lanes)} :
                              (width_q == ESMC_W16) ? {2'h0, beat_q[0] ? be_q[3:2] : be_q[1:0]} :
                              be_q;
   wire [31:0]  rd_merge    = (width_q == ESMC_W8)
                              ? ({24'h0, din_sync[7:0]} << (beat_q * 8))
                              : (width_q == ESMC_W16)
                              ? ({16'h0, din_sync[15:0]} << (beat_q[0] * 16))
                              : din_sync;
   wire [31:0]  lane_mask   = {{8{lanes[3]}}, {8{lanes[2]}}, {8{lanes[1]}}, {8{lanes[0]}}};

   // -----------------------------------------------------------------
   // next state
   // -----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      case (st_q)
         ESMC_IDLE: begin
            if (take && !req_reject) begin
               st_d = need_turn ? ESMC_TURN : ESMC_STROBE;
            end
         end
         ESMC_TURN: begin
            if (cnt_zero) begin
               st_d = ESMC_STROBE;
            end
         end
         ESMC_STROBE: begin
            if (cnt_zero) begin
               st_d = last_b ? ESMC_IDLE : ESMC_HOLD;
            end
         end
         default: begin
            st_d = ESMC_STROBE;
         end
      endcase
   end

   // -----------------------------------------------------------------
   // sequencer
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         st_q <= ESMC_IDLE;
         wait_q <= 1'b0;
         cnt_q <= '0;
         beat_q <= 2'h0;
      end else begin
         st_q <= st_d;
         wait_q <= st_d != ESMC_IDLE;
         if (take && need_turn) begin
            cnt_q <= {2'h0, req_idle};
         end else if (take) begin
            cnt_q <= strobe_len(sys_write, req_wait);
         end else if (st_q != st_d && st_d == ESMC_STROBE) begin
            cnt_q <= strobe_cnt;
         end else if (!cnt_zero) begin
            cnt_q <= cnt_q - 1'b1;
         end
         if (st_q == ESMC_IDLE) begin
            beat_q <= 2'h0;
         end else if (st_q == ESMC_STROBE && cnt_zero) begin
            beat_q <= beat_q + 1'b1;
         end
      end
   end

   // the first beat of a direct start counts from the latch cycle below
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         addr_q <= 24'h0;
         bank_q <= 3'h0;
         we_q <= 1'b0;
         be_q <= 4'h0;
         wdata_q <= 32'h0;
         width_q <= ESMC_W8;
         seq_q <= 1'b0;
      end else if (take) begin
         addr_q <= req_addr;
         bank_q <= req_bank;
         we_q <= sys_write;
         be_q <= sys_byte_en;
         wdata_q <= sys_wdata;
         width_q <= esmc_width_t'(cfg_data_width[req_bank*2 +: 2]);
         seq_q <= req_seq;
      end else if (st_q == ESMC_STROBE && cnt_zero) begin
         seq_q <= burst_b;
      end
   end

   // -----------------------------------------------------------------
   // answer to the system side
   // -----------------------------------------------------------------
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         ready_q <= 1'b0;
         error_q <= 1'b0;
         rdata_q <= 32'h0;
         last_rd_q <= 1'b0;
         last_valid_q <= 1'b0;
         last_bank_q <= 3'h0;
         last_page_q <= 20'h0;
      end else begin
         ready_q <= (take && req_reject)
                    || (st_q == ESMC_STROBE && cnt_zero && last_b);
         error_q <= take && req_reject;
         if (take) begin
            rdata_q <= 32'h0;
         end else if (st_q == ESMC_STROBE && cnt_zero && !we_q) begin
            rdata_q <= (rdata_q & ~lane_mask) | (rd_merge & lane_mask);
         end
         if (st_q == ESMC_STROBE && cnt_zero && last_b) begin
            last_rd_q <= !we_q;
            last_valid_q <= 1'b1;
            last_bank_q <= bank_q;
            last_page_q <= addr_q[23:`ESMC_PAGE_LO];
         end
      end
   end

   // -----------------------------------------------------------------
   // external bus outputs, registered one cycle behind the sequencer
   // -----------------------------------------------------------------
   wire         on_bus     = st_q == ESMC_STROBE || st_q == ESMC_HOLD;
   wire         strobe     = st_q == ESMC_STROBE;
   wire [7:0]   cs_act     = on_bus ? (8'h1 << bank_q) : 8'h0;
   wire [7:0]   cs_d       = ~(cs_act ^ cfg_select_pol);
   wire [3:0]   bls_act    = we_q ? beat_be
                             : (cfg_read_lanes_en[bank_q] ? 4'hf : 4'h0);
   wire [3:0]   bls_n_d    = strobe ? ~bls_act : 4'hf;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         cs_q <= 8'h0;
         bls_n_q <= 4'hf;
         we_n_q <= 1'b1;
         oe_n_q <= 1'b1;
         ext_addr_q <= 24'h0;
         dout_q <= 32'h0;
         doe_n_q <= 1'b1;
      end else begin
         cs_q <= cs_d;
         bls_n_q <= bls_n_d;
         we_n_q <= !(strobe && we_q);
         oe_n_q <= !(strobe && !we_q);
         if (on_bus) begin
            ext_addr_q <= beat_addr;
         end
         dout_q <= beat_wdata;
         // held over the hold gap so the bus stays driven between beats of a write
         doe_n_q <= !(on_bus && we_q);
      end
   end

   esmc_sync u_sync (
      .clk      (clk),
      .resetn   (resetn),
      .async_in (ext_data_bus_in),
      .sync_out (din_sync)
   );

   assign sys_ready              = ready_q;
   assign sys_error              = error_q;
   assign sys_rdata              = rdata_q;
   assign sys_wait               = wait_q;
   assign bank_select_out        = cs_q;
   assign byte_lane_select_out_n = bls_n_q;
   assign ext_write_strobe_n     = we_n_q;
   assign ext_output_enable_n    = oe_n_q;
   assign ext_address_bus        = ext_addr_q;
   assign ext_data_bus_out       = dout_q;
   assign ext_data_bus_oe_n      = doe_n_q;

endmodule : esmc_ctrl

// ---- bench/esmc_ctrl_checker.sv ----
// port-level assertion checker for the external static memory controller
`timescale 1ns/10ps

module esmc_ctrl_checker (
   input wire logic        clk,
   input wire logic        resetn,
   input wire logic        sys_req,
   input wire logic        sys_write,
   input wire logic [31:0] sys_addr,
   input wire logic [3:0]  sys_byte_en,
   input wire logic        sys_ready,
   input wire logic        sys_error,
   input wire logic        sys_wait,
   input wire logic [7:0]  cfg_select_pol,
   input wire logic [15:0] cfg_data_width,
   input wire logic [39:0] cfg_read_wait,
   input wire logic [39:0] cfg_write_wait,
   input wire logic [7:0]  cfg_burst_en,
   input wire logic [7:0]  cfg_write_protect,
   input wire logic [7:0]  cfg_read_lanes_en,
   input wire logic [7:0]  bank_select_out,
   input wire logic [3:0]  byte_lane_select_out_n,
   input wire logic        ext_write_strobe_n,
   input wire logic        ext_output_enable_n,
   input wire logic [23:0] ext_address_bus,
   input wire logic        ext_data_bus_oe_n
);
   logic [2:0] sel;
   logic       take;
   logic       strobe_on;
   logic       wide;
   logic       skip_q;
   logic [5:0] run_q;
   logic [5:0] len_q;

   assign sel = sys_addr[28:26];
   assign take = sys_req && !sys_wait && !sys_ready;
   assign strobe_on = !ext_write_strobe_n || !ext_output_enable_n;
   assign wide = cfg_data_width[sel * 2 +: 2] == 2'h2;

   // burst-bank reads change wait per beat, so their length is left out
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         run_q <= 6'h00;
         len_q <= 6'h00;
         skip_q <= 1'b1;
      end else begin
         run_q <= strobe_on ? run_q + 6'h01 : 6'h00;
         if (take) begin
            len_q <= sys_write ? {1'b0, cfg_write_wait[sel * 5 +: 5]} + 6'h01
                               : {1'b0, cfg_read_wait[sel * 5 +: 5]} + 6'h04;
            skip_q <= !sys_write && cfg_burst_en[sel];
         end
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence quiet_s;
      (ext_write_strobe_n && ext_output_enable_n) [*2];
   endsequence
   sequence refuse_s;
      (sys_ready && sys_error) ##0 quiet_s;
   endsequence

   region_refuse_a: assert property (take && sys_addr[31:29] != 3'h2 |=> refuse_s)
      else $error("out-of-region access not refused");
   protect_refuse_a: assert property (take && sys_addr[31:29] == 3'h2 && sys_write
      && cfg_write_protect[sel] |=> refuse_s) else $error("protected write not refused");
   write_drive_a: assert property (!ext_write_strobe_n |->
      ext_output_enable_n && !ext_data_bus_oe_n) else $error("write strobe without data drive");
   data_release_a: assert property (!ext_output_enable_n ||
      (!sys_wait && !strobe_on && !sys_ready) |-> ext_data_bus_oe_n)
      else $error("data bus driven outside a write");
   select_active_a: assert property (strobe_on && !sys_ready |->
      bank_select_out == ~(cfg_select_pol ^ (8'h01 << sel))) else $error("wrong bank select");
   select_idle_a: assert property (!sys_wait && !strobe_on && $past(resetn) &&
      $stable(cfg_select_pol) |-> bank_select_out == ~cfg_select_pol)
      else $error("bank select active while idle");
   addr_bus_a: assert property (strobe_on && !sys_ready && wide |->
      ext_address_bus == sys_addr[23:0]) else $error("external address wrong");
   read_lanes_a: assert property (!ext_output_enable_n && !cfg_read_lanes_en[sel]
      && !sys_ready |-> byte_lane_select_out_n == 4'hf) else $error("lanes low on read");
   write_lanes_a: assert property (!ext_write_strobe_n && wide |->
      byte_lane_select_out_n == ~sys_byte_en) else $error("write lanes wrong");
   strobe_len_a: assert property (!skip_q && $fell(strobe_on) |-> run_q == len_q)
      else $error("strobe length wrong");
   ready_end_a: assert property (sys_ready && !sys_error |->
      (sys_write ? !ext_write_strobe_n : !ext_output_enable_n) ##1
      (ext_write_strobe_n && ext_output_enable_n)) else $error("ready not at strobe end");
endmodule : esmc_ctrl_checker

bind esmc_ctrl esmc_ctrl_checker i_esmc_ctrl_checker (.clk, .resetn, .sys_req, .sys_write,
   .sys_addr, .sys_byte_en, .sys_ready, .sys_error, .sys_wait, .cfg_select_pol,
   .cfg_data_width, .cfg_read_wait, .cfg_write_wait, .cfg_burst_en, .cfg_write_protect,
   .cfg_read_lanes_en, .bank_select_out, .byte_lane_select_out_n, .ext_write_strobe_n,
   .ext_output_enable_n, .ext_address_bus, .ext_data_bus_oe_n);

// ---- bench/esmc_mem_model.sv ----
// behavioural static memory on the far side of the external bus
`timescale 1ns/10ps

module esmc_mem_model (
   input  wire logic        clk,
   input  wire logic [7:0]  bank_select_out,
   input  wire logic [7:0]  cfg_select_pol,
   input  wire logic [15:0] cfg_data_width,
   input  wire logic [3:0]  byte_lane_select_out_n,
   input  wire logic        ext_write_strobe_n,
   input  wire logic        ext_output_enable_n,
   input  wire logic [23:0] ext_address_bus,
   input  wire logic [31:0] data_bus,
   output logic      [31:0] mem_dq
);
   logic [31:0] mem_q [0:511];
   logic [31:0] last_q = 32'h5a5a_a5a5;
   logic [7:0]  hit;
   logic [2:0]  bank;
   logic [8:0]  idx;
   logic        narrow;

   assign hit = ~(bank_select_out ^ cfg_select_pol);
   always_comb begin
      bank = 3'h0;
      for (int i = 0; i < 8; i++) begin
         if (hit[i]) begin
            bank = i[2:0];
         end
      end
   end
   assign idx = {bank, ext_address_bus[5:0]};
   assign narrow = cfg_data_width[bank * 2 +: 2] < 2'h2;
   // a released bus flips each cycle so stale data never passes for a read
   assign mem_dq = (!ext_output_enable_n && hit != 8'h00) ? mem_q[idx] : ~last_q;

   always @(posedge clk) begin
      last_q <= mem_dq;
      if (!ext_write_strobe_n && hit != 8'h00) begin
         for (int i = 0; i < 4; i++) begin
            if (narrow || !byte_lane_select_out_n[i]) begin
               mem_q[idx][8 * i +: 8] <= data_bus[8 * i +: 8];
            end
         end
      end
   end
endmodule : esmc_mem_model

// ---- bench/esmc_ctrl_tb.sv ----
// self-checking testbench for the external static memory controller
`timescale 1ns/10ps

module esmc_ctrl_tb;
   logic        clk, resetn, sys_req, sys_write, sys_ready, sys_error, sys_wait, err_v;
   logic [31:0] sys_addr, sys_wdata, sys_rdata, ext_data_bus_out, mem_dq, rd_v;
   logic [3:0]  sys_byte_en, byte_lane_select_out_n;
   logic [7:0]  cfg_select_pol, cfg_burst_en, cfg_write_protect, cfg_read_lanes_en;
   logic [7:0]  bank_select_out;
   logic [15:0] cfg_data_width;
   logic [39:0] cfg_read_wait, cfg_write_wait, cfg_burst_wait;
   logic [31:0] cfg_turnaround_idle_cycles;
   logic        ext_write_strobe_n, ext_output_enable_n, ext_data_bus_oe_n;
   logic [23:0] ext_address_bus;
   wire  [31:0] ext_data_bus_in;
   int          bad_count, total_checks, lat_v;

   assign ext_data_bus_in = ext_data_bus_oe_n ? mem_dq : ext_data_bus_out;

   esmc_ctrl i_esmc_ctrl (.clk, .resetn, .sys_req, .sys_write, .sys_addr, .sys_byte_en,
      .sys_wdata, .sys_ready, .sys_error, .sys_wait, .sys_rdata, .cfg_select_pol,
      .cfg_data_width, .cfg_read_wait, .cfg_write_wait, .cfg_burst_wait,
      .cfg_turnaround_idle_cycles, .cfg_burst_en, .cfg_write_protect, .cfg_read_lanes_en,
      .bank_select_out, .byte_lane_select_out_n, .ext_write_strobe_n, .ext_output_enable_n,
      .ext_address_bus, .ext_data_bus_out, .ext_data_bus_oe_n, .ext_data_bus_in);
   esmc_mem_model i_esmc_mem_model (.clk, .bank_select_out, .cfg_select_pol,
      .cfg_data_width, .byte_lane_select_out_n, .ext_write_strobe_n, .ext_output_enable_n,
      .ext_address_bus, .data_bus(ext_data_bus_in), .mem_dq);

   // -------------------------------------------------
   // shared tasks
   // -------------------------------------------------
   task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   // lat_v counts edges from the take to the ready pulse
   task automatic xs(input logic wr, input logic [31:0] a, input logic [3:0] be,
                     input logic [31:0] wd);
      @(negedge clk);
      lat_v = -1;
      sys_write = wr;
      sys_addr = a;
      sys_byte_en = be;
      sys_wdata = wd;
      sys_req = 1'b1;
      do begin
         @(negedge clk);
         lat_v++;
      end while (sys_ready !== 1'b1 && lat_v < 300);
      check("ready_seen", 32'h1, {31'h0, sys_ready});
      sys_req = 1'b0;
      rd_v = sys_rdata;
      err_v = sys_error;
   endtask : xs

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : print_verdict

   // -------------------------------------------------
   // scenarios
   // -------------------------------------------------
   task automatic t_banks;
      logic [31:0] a;
      for (int b = 0; b < 8; b++) begin
         a = {3'h2, b[2:0], 2'h0, 24'h000100};
         xs(1'b1, a, 4'hf, 32'h5a00_0011 + b);
         xs(1'b0, a, 4'hf, 32'h0);
         check("bank_rdata", 32'h5a00_0011 + b, rd_v);
         check("bank_err", 32'h0, {31'h0, err_v});
      end
      xs(1'b1, 32'h4f00_0200, 4'hf, 32'hc3c3_1234);
      xs(1'b0, 32'h4c00_0200, 4'hf, 32'h0);
      check("mirror_rdata", 32'hc3c3_1234, rd_v);
   endtask : t_banks

   task automatic t_refuse;
      xs(1'b0, 32'h6c00_0000, 4'hf, 32'h0);
      check("region_err", 32'h1, {31'h0, err_v});
      check("region_lat", 32'h0, lat_v);
      cfg_write_protect = 8'h10;
      xs(1'b1, 32'h5000_0100, 4'hf, 32'hdead_0000);
      check("protect_err", 32'h1, {31'h0, err_v});
      xs(1'b0, 32'h5000_0100, 4'hf, 32'h0);
      check("protect_rdata", 32'h5a00_0015, rd_v);
      cfg_write_protect = 8'h00;
   endtask : t_refuse

   task automatic t_lanes;
      xs(1'b1, 32'h4000_0040, 4'hf, 32'hffff_ffff);
      xs(1'b1, 32'h4000_0040, 4'h5, 32'h1122_3344);
      cfg_read_lanes_en = 8'hfe;
      xs(1'b0, 32'h4000_0040, 4'hf, 32'h0);
      check("lane_rdata", 32'hff22_ff44, rd_v);
      cfg_read_lanes_en = 8'hff;
   endtask : t_lanes

   task automatic t_wait;
      cfg_write_wait[25 +: 5] = 5'h07;
      cfg_read_wait[25 +: 5] = 5'h05;
      for (int v = 0; v < 16; v += 15) begin
         cfg_turnaround_idle_cycles = {8{v[3:0]}};
         xs(1'b1, 32'h5400_0000, 4'hf, 32'h0bad_0001);
         xs(1'b1, 32'h5400_0000, 4'hf, 32'h0bad_0002);
         check("write_lat", 32'h8, lat_v);
         xs(1'b0, 32'h5400_0000, 4'hf, 32'h0);
         check("read_lat", 32'h9, lat_v);
         check("read_rdata", 32'h0bad_0002, rd_v);
         xs(1'b1, 32'h5400_0000, 4'hf, 32'h0bad_0003);
         check("turn_lat", 32'h9 + v, lat_v);
      end
   endtask : t_wait

   task automatic t_burst;
      cfg_burst_en = 8'h80;
      cfg_read_wait[35 +: 5] = 5'h1f;
      cfg_burst_wait[35 +: 5] = 5'h02;
      xs(1'b1, 32'h5c00_0080, 4'hf, 32'h0000_00a1);
      xs(1'b1, 32'h5c00_0084, 4'hf, 32'h0000_00b2);
      xs(1'b0, 32'h5c00_0080, 4'hf, 32'h0);
      check("first_lat", 32'h23, lat_v);
      check("first_rdata", 32'h0000_00a1, rd_v);
      xs(1'b0, 32'h5c00_0084, 4'hf, 32'h0);
      check("next_lat", 32'h6, lat_v);
      check("next_rdata", 32'h0000_00b2, rd_v);
      cfg_burst_en = 8'h00;
      xs(1'b0, 32'h5c00_0084, 4'hf, 32'h0);
      check("off_lat", 32'h23, lat_v);
   endtask : t_burst

   // -------------------------------------------------
   // clock, watchdog, main sequence
   // -------------------------------------------------
   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // the whole run needs well under 1500 cycles
   initial begin
      #(3000 * 100);
      bad_count++;
      print_verdict;
   end

   initial begin
      bad_count = 0;
      total_checks = 0;
      resetn = 1'b0;
      sys_req = 1'b0;
      sys_write = 1'b0;
      sys_addr = 32'h0;
      sys_byte_en = 4'h0;
      sys_wdata = 32'h0;
      cfg_select_pol = 8'ha5;
      cfg_data_width = 16'haa86;
      cfg_read_wait = 40'h0;
      cfg_write_wait = 40'h0;
      cfg_burst_wait = 40'h0;
      cfg_turnaround_idle_cycles = 32'h0;
      cfg_burst_en = 8'h00;
      cfg_write_protect = 8'h00;
      cfg_read_lanes_en = 8'hff;
      repeat (3) @(negedge clk);
      check("select_rst", 32'h0, {24'h0, bank_select_out});
      check("strobe_rst", 32'h7, {29'h0, ext_write_strobe_n, ext_output_enable_n,
         ext_data_bus_oe_n});
      resetn = 1'b1;
      t_banks;
      t_refuse;
      t_lanes;
      t_wait;
      t_burst;
      print_verdict;
   end
endmodule : esmc_ctrl_tb
